// ### rtl/dpu_consts.vh
// Constants for the pixel stream unpacker and colour expander.
// Assumes bytes arrive in order from the link receiver on the same clock.
// Behaviour
// - Type 0Eh is 16-bit R5 G6 B5 stream
// - Packet is ID, count, ECC, payload, checksum
// - Component bits travel least significant first
// - 16-bit green spans two bytes, two bytes/pixel
// - Type 1Eh is packed 18-bit, nine bytes per four
// - Drop filler pixels beyond the active width
// - Type 2Eh takes bits 7:2, three bytes/pixel
// - Type 3Eh takes whole R, G, B bytes
// - Fill mode 00 appends zero bits
// - Fill mode 01 appends one bits
// - Fill mode 10 appends the component top bits
// - Fill mode 11 behaves as fill mode 10
`ifndef DPU_CONSTS_VH
`define DPU_CONSTS_VH

// Data type codes, low six bits of the identifier byte
`define DPU_DT_RGB16    6'h0E
`define DPU_DT_RGB18P   6'h1E
`define DPU_DT_RGB18L   6'h2E
`define DPU_DT_RGB24    6'h3E

// Internal format codes
`define DPU_FMT_NONE    3'h0
`define DPU_FMT_16      3'h1
`define DPU_FMT_18P     3'h2
`define DPU_FMT_18L     3'h3
`define DPU_FMT_24      3'h4

// Bits per pixel and bits taken per byte
`define DPU_BITS_16     6'h10
`define DPU_BITS_18     6'h12
`define DPU_BITS_24     6'h18
`define DPU_BYTE_FULL   6'h08
`define DPU_BYTE_LOOSE  6'h06

// Fill modes
`define DPU_FILL_ZERO   2'h0
`define DPU_FILL_ONE    2'h1

// Pixel buffer shape and stall margin
`define DPU_FIFO_WIDTH  24
`define DPU_FIFO_DEPTH  16
`define DPU_FIFO_AW     4
`define DPU_FIFO_STOP   5'h0E

`endif

// ### rtl/dpu_fifo.v
// Pixel buffer: synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data is shown ahead from the head slot.
`timescale 1ns/1ns
module dpu_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             sys_rst_i,
  // Fill side
  input  wire             wr_valid_i,
  output wire             wr_ready_o,
  input  wire [WIDTH-1:0] wr_data_i,
  // Drain side
  output wire             rd_valid_o,
  input  wire             rd_ready_i,
  output wire [WIDTH-1:0] rd_data_o,
  // Fill level
  output wire [AW:0]      level_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            push;
  wire            pop;

  // Full when pointers differ only in the wrap bit
  assign level_o    = wr_ptr_reg - rd_ptr_reg;
  assign wr_ready_o = (level_o != DEPTH[AW:0]);
  assign rd_valid_o = (wr_ptr_reg != rd_ptr_reg);
  assign rd_data_o  = mem[rd_ptr_reg[AW-1:0]];
  assign push       = wr_valid_i & wr_ready_o;
  assign pop        = rd_valid_o & rd_ready_i;

  // Storage write
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= wr_data_i;
    end
  end

  // Pointer update
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule

// ### rtl/dpu_unpack.v
// Pixel stream unpacker: frames long packets, unpacks the four pixel
// formats, drops filler pixels and widens colour to 24 bits.
// Assumes the byte source and the fill mode setting share clk_i, and
// that only long packets are presented on the byte port.
`timescale 1ns/1ns
`include "dpu_consts.vh"
module dpu_unpack (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Packet byte stream from the link receiver
  input  wire        byte_valid_i,
  input  wire        byte_sop_i,
  input  wire [7:0]  byte_data_i,
  output reg         byte_ready_o,
  // Line control and settings
  input  wire        line_start_i,
  input  wire [15:0] active_width_i,
  input  wire [1:0]  colour_expand_fill_mode_i,
  // Expanded pixel output
  output reg         pix_valid_o,
  input  wire        pix_ready_i,
  output reg  [7:0]  pix_red_o,
  output reg  [7:0]  pix_green_o,
  output reg  [7:0]  pix_blue_o,
  // Status
  output reg  [2:0]  pix_format_o,
  output reg         pkt_done_o,
  output reg         pkt_ignored_o,
  output reg         filler_drop_o
);

  // Framing states
  localparam ST_IDLE = 3'h0;
  localparam ST_WC0  = 3'h1;
  localparam ST_WC1  = 3'h2;
  localparam ST_ECC  = 3'h3;
  localparam ST_PAY  = 3'h4;
  localparam ST_CS0  = 3'h5;
  localparam ST_CS1  = 3'h6;

  // Widen one component; five selects 5-bit input in c[4:0]
  function [7:0] dpu_expand;
    input [5:0] c;
    input       five;
    input [1:0] mode;
    begin
      if (five) begin
        case (mode)
          `DPU_FILL_ZERO: dpu_expand = {c[4:0], 3'h0};
          `DPU_FILL_ONE:  dpu_expand = {c[4:0], 3'h7};
          default:        dpu_expand = {c[4:0], c[4:2]};
        endcase
      end else begin
        case (mode)
          `DPU_FILL_ZERO: dpu_expand = {c, 2'h0};
          `DPU_FILL_ONE:  dpu_expand = {c, 2'h3};
          default:        dpu_expand = {c, c[5:4]};
        endcase
      end
    end
  endfunction

  // Map data type to internal format
  function [2:0] dpu_format;
    input [5:0] dt;
    begin
      case (dt)
        `DPU_DT_RGB16:  dpu_format = `DPU_FMT_16;
        `DPU_DT_RGB18P: dpu_format = `DPU_FMT_18P;
        `DPU_DT_RGB18L: dpu_format = `DPU_FMT_18L;
        `DPU_DT_RGB24:  dpu_format = `DPU_FMT_24;
        default:        dpu_format = `DPU_FMT_NONE;
      endcase
    end
  endfunction

  // Framing state
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [2:0]  fmt_reg;
  reg  [15:0] wc_reg;
  reg  [15:0] left_reg;
  // Bit accumulator
  reg  [31:0] acc_reg;
  reg  [5:0]  cnt_reg;
  reg  [15:0] line_pix_reg;
  // Combinational unpack results
  reg  [5:0]  take_bits;
  reg  [5:0]  pix_bits;
  reg  [7:0]  new_bits;
  reg  [31:0] merged;
  reg  [5:0]  cnt_sum;
  reg         pix_hit;
  reg  [23:0] pix_rgb;
  reg  [5:0]  comp_r;
  reg  [5:0]  comp_g;
  reg  [5:0]  comp_b;
  reg         comp_five;
  // Buffer wiring
  wire        take;
  wire        in_active;
  wire        push;
  wire        fifo_wr_ready;
  wire        fifo_rd_valid;
  wire [23:0] fifo_rd_data;
  wire        fifo_pop;
  wire [4:0]  fifo_level;

  assign take      = byte_valid_i & byte_ready_o;
  assign in_active = (active_width_i == 16'h0000) || (line_pix_reg < active_width_i);

  // Framing sequence: id, count low, count high, ECC, payload, checksum
  always @* begin
    state_next = state_reg;
    if (take) begin
      if (byte_sop_i) begin
        state_next = ST_WC0;
      end else begin
        case (state_reg)
          ST_WC0:  state_next = ST_WC1;
          ST_WC1:  state_next = ST_ECC;
          ST_ECC:  state_next = (wc_reg == 16'h0000) ? ST_CS0 : ST_PAY;
          ST_PAY:  state_next = (left_reg == 16'h0001) ? ST_CS0 : ST_PAY;
          ST_CS0:  state_next = ST_CS1;
          ST_CS1:  state_next = ST_IDLE;
          default: state_next = ST_IDLE;
        endcase
      end
    end
  end

  // Per-format widths of one pixel and of each payload byte
  always @* begin
    case (fmt_reg)
      `DPU_FMT_16:  pix_bits = `DPU_BITS_16;
      `DPU_FMT_24:  pix_bits = `DPU_BITS_24;
      default:      pix_bits = `DPU_BITS_18;
    endcase
    if (fmt_reg == `DPU_FMT_18L) begin
      take_bits = `DPU_BYTE_LOOSE;
      new_bits  = {2'b00, byte_data_i[7:2]};
    end else begin
      take_bits = `DPU_BYTE_FULL;
      new_bits  = byte_data_i;
    end
  end

  // Append byte above held bits; first bit on the wire is the lowest
  always @* begin
    merged  = acc_reg | ({24'h00_0000, new_bits} << cnt_reg);
    cnt_sum = cnt_reg + take_bits;
    pix_hit = (state_reg == ST_PAY) && take && !byte_sop_i &&
              (fmt_reg != `DPU_FMT_NONE) && (cnt_sum >= pix_bits);
  end

  // Split the completed pixel into components, red lowest
  always @* begin
    comp_five = 1'b0;
    comp_r    = 6'h00;
    comp_g    = 6'h00;
    comp_b    = 6'h00;
    pix_rgb   = 24'h00_0000;
    case (fmt_reg)
      `DPU_FMT_16: begin
        comp_five = 1'b1;
        comp_r    = {1'b0, merged[4:0]};
        comp_g    = merged[10:5];
        comp_b    = {1'b0, merged[15:11]};
      end
      `DPU_FMT_18P, `DPU_FMT_18L: begin
        comp_r = merged[5:0];
        comp_g = merged[11:6];
        comp_b = merged[17:12];
      end
      default: begin
        comp_r = 6'h00;
      end
    endcase
    if (fmt_reg == `DPU_FMT_24) begin
      pix_rgb = {merged[7:0], merged[15:8], merged[23:16]};
    end else begin
      pix_rgb = {dpu_expand(comp_r, comp_five, colour_expand_fill_mode_i),
                 dpu_expand(comp_g, 1'b0, colour_expand_fill_mode_i),
                 dpu_expand(comp_b, comp_five, colour_expand_fill_mode_i)};
    end
  end

  // Only pixels inside the active width reach the buffer
  assign push = pix_hit & in_active;

  // Framing registers
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      fmt_reg   <= `DPU_FMT_NONE;
      wc_reg    <= 16'h0000;
      left_reg  <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (take) begin
        if (byte_sop_i) begin
          fmt_reg <= dpu_format(byte_data_i[5:0]);
        end else if (state_reg == ST_WC0) begin
          wc_reg[7:0] <= byte_data_i;
        end else if (state_reg == ST_WC1) begin
          wc_reg[15:8] <= byte_data_i;
        end else if (state_reg == ST_ECC) begin
          left_reg <= wc_reg;
        end else if (state_reg == ST_PAY) begin
          left_reg <= left_reg - 16'h0001;
        end
      end
    end
  end

  // Bit accumulator; cleared at each packet start so no bits leak over
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
    end else if (take && byte_sop_i) begin
      acc_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
    end else if (take && (state_reg == ST_PAY) && (fmt_reg != `DPU_FMT_NONE)) begin
      if (cnt_sum >= pix_bits) begin
        acc_reg <= merged >> pix_bits;
        cnt_reg <= cnt_sum - pix_bits;
      end else begin
        acc_reg <= merged;
        cnt_reg <= cnt_sum;
      end
    end
  end

  // Pixel position within the current line
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      line_pix_reg <= 16'h0000;
    end else if (line_start_i) begin
      line_pix_reg <= 16'h0000;
    end else if (pix_hit && (line_pix_reg != 16'hFFFF)) begin
      line_pix_reg <= line_pix_reg + 16'h0001;
    end
  end

  // Byte stall: ready only while the buffer holds fewer than 14 pixels
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      byte_ready_o <= 1'b0;
    end else begin
      byte_ready_o <= fifo_wr_ready && (fifo_level < `DPU_FIFO_STOP);
    end
  end

  // Status pulses and current format
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pix_format_o  <= `DPU_FMT_NONE;
      pkt_done_o    <= 1'b0;
      pkt_ignored_o <= 1'b0;
      filler_drop_o <= 1'b0;
    end else begin
      pix_format_o  <= fmt_reg;
      pkt_done_o    <= take && !byte_sop_i && (state_reg == ST_CS1);
      pkt_ignored_o <= take && !byte_sop_i && (state_reg == ST_ECC) &&
                       (fmt_reg == `DPU_FMT_NONE);
      filler_drop_o <= pix_hit && !in_active;
    end
  end

  // Pixel buffer between unpacker and output
  dpu_fifo #(
    .WIDTH (`DPU_FIFO_WIDTH),
    .DEPTH (`DPU_FIFO_DEPTH),
    .AW    (`DPU_FIFO_AW)
  ) u_fifo (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_valid_i (push),
    .wr_ready_o (fifo_wr_ready),
    .wr_data_i  (pix_rgb),
    .rd_valid_o (fifo_rd_valid),
    .rd_ready_i (fifo_pop),
    .rd_data_o  (fifo_rd_data),
    .level_o    (fifo_level)
  );

  // Output holding register refills when empty or taken
  assign fifo_pop = fifo_rd_valid & (~pix_valid_o | pix_ready_i);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pix_valid_o <= 1'b0;
      pix_red_o   <= 8'h00;
      pix_green_o <= 8'h00;
      pix_blue_o  <= 8'h00;
    end else if (~pix_valid_o | pix_ready_i) begin
      pix_valid_o <= fifo_rd_valid;
      if (fifo_rd_valid) begin
        pix_red_o   <= fifo_rd_data[23:16];
        pix_green_o <= fifo_rd_data[15:8];
        pix_blue_o  <= fifo_rd_data[7:0];
      end
    end
  end

endmodule

// ### tb/dpu_unpack_chk.sv
// Checker for the pixel unpacker: header framing, format and fill relations.
// Assumes fill mode and format are settled while buffered pixels drain.
`timescale 1ns/1ns
`include "dpu_consts.vh"
module dpu_unpack_chk (
  // Clock, reset and byte port
  input wire logic       clk_i, sys_rst_i, byte_valid_i, byte_sop_i, byte_ready_o,
  input wire logic [7:0] byte_data_i,
  // Pixel port and status
  input wire logic       pix_valid_o, pix_ready_i, pkt_done_o, pkt_ignored_o,
  input wire logic [7:0] pix_red_o, pix_green_o, pix_blue_o,
  input wire logic [1:0] colour_expand_fill_mode_i,
  input wire logic [2:0] pix_format_o
);
  logic [2:0] hdr_reg;
  logic [5:0] dt_reg;
  wire        acc = byte_valid_i && byte_ready_o;
  wire        none = dt_reg != `DPU_DT_RGB16 && dt_reg != `DPU_DT_RGB18P &&
                     dt_reg != `DPU_DT_RGB18L && dt_reg != `DPU_DT_RGB24;
  wire [2:0]  fmt = dt_reg == `DPU_DT_RGB16 ? `DPU_FMT_16 : dt_reg == `DPU_DT_RGB18P ?
                    `DPU_FMT_18P : dt_reg == `DPU_DT_RGB18L ? `DPU_FMT_18L : `DPU_FMT_24;
  wire        f16 = pix_format_o == `DPU_FMT_16;
  wire        f18 = pix_format_o == `DPU_FMT_18P || pix_format_o == `DPU_FMT_18L;
  // Low fill bits and the top bits they may copy
  wire [7:0]  lo16 = {pix_red_o[2:0], pix_green_o[1:0], pix_blue_o[2:0]};
  wire [7:0]  hi16 = {pix_red_o[7:5], pix_green_o[7:6], pix_blue_o[7:5]};
  wire [5:0]  lo18 = {pix_red_o[1:0], pix_green_o[1:0], pix_blue_o[1:0]};
  wire [5:0]  hi18 = {pix_red_o[7:6], pix_green_o[7:6], pix_blue_o[7:6]};
  // Header byte position since the last identifier byte
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      hdr_reg <= 3'h4;
    end else if (acc && byte_sop_i) begin
      hdr_reg <= 3'h1;
      dt_reg  <= byte_data_i[5:0];
    end else if (acc && hdr_reg != 3'h4) begin
      hdr_reg <= hdr_reg + 3'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_ecc;
    acc && !byte_sop_i && hdr_reg == 3'h3;
  endsequence
  sequence s_gone;
    !pkt_done_o;
  endsequence
  AST_RESET: assert property (disable iff (1'b0) sys_rst_i |=> !byte_ready_o && !pix_valid_o)
    else $error("output active after reset");
  AST_FMT: assert property (s_ecc ##0 !none |=> pix_format_o == fmt)
    else $error("wrong format");
  AST_IGN: assert property (s_ecc ##0 none |=> pkt_ignored_o)
    else $error("unknown type not ignored");
  AST_DONE: assert property (pkt_done_o |-> $past(acc) ##1 s_gone)
    else $error("bad done pulse");
  AST_HOLD: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o &&
    $stable({pix_red_o, pix_green_o, pix_blue_o})) else $error("pixel dropped");
  AST_ZERO: assert property (pix_valid_o && colour_expand_fill_mode_i == `DPU_FILL_ZERO
    |-> (!f16 || lo16 == 8'h00) && (!f18 || lo18 == 6'h00)) else $error("zero fill");
  AST_ONE: assert property (pix_valid_o && colour_expand_fill_mode_i == `DPU_FILL_ONE
    |-> (!f16 || lo16 == 8'hFF) && (!f18 || lo18 == 6'h3F)) else $error("one fill");
  AST_TOP: assert property (pix_valid_o && colour_expand_fill_mode_i[1] |->
    (!f16 || lo16 == hi16) && (!f18 || lo18 == hi18)) else $error("top fill");
endmodule
bind dpu_unpack dpu_unpack_chk u_chk (.clk_i, .sys_rst_i, .byte_valid_i, .byte_sop_i,
  .byte_ready_o, .byte_data_i, .pix_valid_o, .pix_ready_i, .pkt_done_o, .pkt_ignored_o,
  .pix_red_o, .pix_green_o, .pix_blue_o, .colour_expand_fill_mode_i, .pix_format_o);

// ### tb/dpu_host_mdl.sv
// Host model: streams packet bytes, each held until a rising edge sees ready.
// Assumes the bench calls put and idle from one sequence.
`timescale 1ns/1ns
module dpu_host_mdl (
  input  wire logic       clk_i,
  input  wire logic       rdy_i,
  output logic            vld_o,
  output logic            sop_o,
  output logic [7:0]      dat_o
);
  initial begin
    vld_o = 1'b0;
    sop_o = 1'b0;
    dat_o = 8'h00;
  end
  // Released lines show the inverse of the last byte
  task automatic idle();
    @(negedge clk_i);
    vld_o = 1'b0;
    sop_o = 1'b0;
    dat_o = ~dat_o;
  endtask
  // One byte after an optional gap, bit 0 first on the wire
  task automatic put(input logic [7:0] d, input logic s, input int gap);
    if (gap > 0) begin
      idle();
      repeat (gap - 1) @(negedge clk_i);
    end
    @(negedge clk_i);
    vld_o = 1'b1;
    sop_o = s;
    dat_o = d;
    @(posedge clk_i);
    while (rdy_i !== 1'b1) @(posedge clk_i);
  endtask
endmodule

// ### tb/tb.sv
// Bench for the pixel unpacker: every format and fill mode, filler and stall.
// Assumes the host model drives the byte port and the checker is bound.
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        line_start_i = 1'b0;
  logic        pix_ready_i = 1'b0;
  logic        hold = 1'b0;
  logic        full = 1'b0;
  logic [15:0] active_width_i = 16'h0000;
  logic [1:0]  fm = 2'h0;
  logic [31:0] rs = 32'h0000_002B;
  logic [23:0] exp_px;
  logic [23:0] expq[$];
  logic [7:0]  pl[$];
  logic [5:0]  dts[4] = '{6'h0E, 6'h1E, 6'h2E, 6'h3E};
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          ndone = 0;
  int          nign = 0;
  int          ndrop = 0;
  wire         byte_valid_i, byte_sop_i, byte_ready_o, pix_valid_o;
  wire         pkt_done_o, pkt_ignored_o, filler_drop_o;
  wire [7:0]   byte_data_i, pix_red_o, pix_green_o, pix_blue_o;
  wire [2:0]   pix_format_o;
  dpu_host_mdl u_host (.clk_i, .rdy_i(byte_ready_o), .vld_o(byte_valid_i),
    .sop_o(byte_sop_i), .dat_o(byte_data_i));
  dpu_unpack u_dut (.clk_i, .sys_rst_i, .byte_valid_i, .byte_sop_i, .byte_data_i,
    .byte_ready_o, .line_start_i, .active_width_i, .colour_expand_fill_mode_i(fm),
    .pix_valid_o, .pix_ready_i, .pix_red_o, .pix_green_o, .pix_blue_o, .pix_format_o,
    .pkt_done_o, .pkt_ignored_o, .filler_drop_o);
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Expected widening of a 5-bit (f) or 6-bit component
  function automatic logic [7:0] ex(input logic [5:0] c, input logic f);
    logic [7:0] v;
    v = f ? {c[4:0], 3'h0} : {c, 2'h0};
    if (fm == 2'h1) v = v | (f ? 8'h07 : 8'h03);
    if (fm[1]) v = v | (f ? {5'h00, c[4:2]} : {6'h00, c[5:4]});
    return v;
  endfunction
  // One line of n pixels in one packet, expectations queued as expanded
  task automatic pkt(input logic [5:0] dt, input int n, input logic [15:0] aw);
    logic [7:0]  e[3];
    logic [5:0]  c[3];
    logic [71:0] bits;
    logic [15:0] wc;
    logic [23:0] px;
    pl.delete();
    bits = 72'h0;
    for (int i = 0; i < n; i++) begin
      foreach (e[j]) begin
        e[j] = 8'(xs());
        c[j] = e[j][5:0];
      end
      px = {ex(c[0], 1'b0), ex(c[1], 1'b0), ex(c[2], 1'b0)};
      case (dt)
        6'h0E: begin
          pl.push_back({c[1][2:0], c[0][4:0]});
          pl.push_back({c[2][4:0], c[1][5:3]});
          px = {ex(c[0], 1'b1), ex(c[1], 1'b0), ex(c[2], 1'b1)};
        end
        6'h1E: begin
          bits[18*(i%4) +: 18] = {c[2], c[1], c[0]};
          if (i % 4 == 3) for (int k = 0; k < 9; k++) pl.push_back(bits[8*k +: 8]);
        end
        6'h2E: foreach (c[j]) pl.push_back({c[j], e[j][7:6]});
        default: begin
          foreach (e[j]) pl.push_back(e[j]);
          px = {e[0], e[1], e[2]};
        end
      endcase
      if (dt != 6'h39 && (aw == 0 || i < aw)) expq.push_back(px);
    end
    wc = 16'(pl.size());
    @(negedge clk_i);
    active_width_i = aw;
    line_start_i = 1'b1;
    @(negedge clk_i);
    line_start_i = 1'b0;
    u_host.put({2'h0, dt}, 1'b1, 0);
    u_host.put(wc[7:0], 1'b0, 0);
    u_host.put(wc[15:8], 1'b0, 0);
    u_host.put(8'(xs()), 1'b0, 0);
    foreach (pl[k]) u_host.put(pl[k], 1'b0, int'(xs() % 3 == 0));
    repeat (2) u_host.put(8'(xs()), 1'b0, 0);
    u_host.idle();
    for (int k = 0; k < 3000 && expq.size() > 0; k++) @(posedge clk_i);
    `CHK(expq.size(), 0)
    repeat (4) @(posedge clk_i);
  endtask
  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #10 clk_i = ~clk_i;
  // Sink stalls at random, or wholly while hold is set
  always @(negedge clk_i) pix_ready_i <= !hold && xs() % 4 != 0;
  // Watch outputs, compare each pixel with the oldest note
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      stop_test();
    end
    if (!sys_rst_i) begin
      if (pix_valid_o === 1'b1 && pix_ready_i) begin
        exp_px = expq.size() > 0 ? expq.pop_front() : 'x;
        `CHK({pix_red_o, pix_green_o, pix_blue_o}, exp_px)
      end
      ndone += int'(pkt_done_o === 1'b1);
      nign += int'(pkt_ignored_o === 1'b1);
      ndrop += int'(filler_drop_o === 1'b1);
      if (hold && byte_ready_o === 1'b0) full = 1'b1;
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    for (int m = 0; m < 4; m++) begin
      @(negedge clk_i);
      fm = 2'(m);
      foreach (dts[d]) pkt(dts[d], 4, 16'h0000);
    end
    pkt(6'h1E, 8, 16'h0007);
    pkt(6'h39, 2, 16'h0000);
    hold = 1'b1;
    fork
      pkt(6'h3E, 20, 16'h0000);
      begin
        repeat (100) @(negedge clk_i);
        hold = 1'b0;
      end
    join
    `CHK(full, 1'b1)
    `CHK(ndone, 19)
    `CHK(nign, 1)
    `CHK(ndrop, 1)
    stop_test();
  end
endmodule
